// ===== src/regbank_pkg.sv
package regbank_pkg;

  // ****************************************************************
  // Bus geometry and address map
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int REPS_MAX = 4;
  localparam logic [ADDR_W-1:0] TEST_ID_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] TEST_SCRATCH_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] VAL_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] STAT_BASE = 8'h30;
  localparam logic [ADDR_W-1:0] EXT_BASE = 8'h40;

  // ****************************************************************
  // Register widths, field layout and reset values
  // ****************************************************************
  localparam int CTRL_W = 8;
  localparam int MODE_W = 4;
  localparam int VAL_W = 16;
  localparam logic [3:0] FREQ_RST = 4'h1;
  localparam logic PLL_RESET_RST = 1'b1;
  localparam logic [2:0] LAUNCH_RST = 3'h0;
  localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
  localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] SCRATCH_RST = 32'h0000_0000;

  typedef logic [DATA_W-1:0] word_t;
  typedef logic signed [MODE_W-1:0] mode_t;
  typedef logic [VAL_W-1:0] val_t;

  // Packed members run from the top bit down: launch is [7:5].
  typedef struct packed {
    logic [2:0] launch;
    logic pll_reset;
    logic [3:0] freq;
  } ctrl_s;

  localparam ctrl_s CTRL_RST = '{launch: LAUNCH_RST, pll_reset: PLL_RESET_RST, freq: FREQ_RST};

  typedef struct packed {
    ctrl_s ctrl;
    logic ctrl_stb;
    mode_t mode;
    val_t [REPS_MAX-1:0] val;
    logic [REPS_MAX-1:0] val_stb;
    logic [REPS_MAX-1:0] stat_ack;
  } out_regs_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    word_t dat;
  } ext_req_s;

  typedef enum {ST_IDLE, ST_EXT, ST_DONE} bus_state_e;

endpackage : regbank_pkg

// ===== src/regbank.sv
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ns
module regbank
  import regbank_pkg::*;
#(
  parameter int MASTERS = 1,
  parameter int VAL_REPS = 2,
  parameter int STAT_REPS = 2,
  parameter int HAS_MODE = 1,
  parameter int RESERVED_WORDS = 4,
  parameter int TESTDEV_ENA = 1,
  parameter int AGGR_OUTS = 0,
  parameter int CTRL_STB_ENA = 1,
  parameter int VAL_STB_ENA = 1,
  parameter int STAT_ACK_ENA = 1,
  parameter int EXT_ADDRBITS = 4,
  // Arbitrary identification value of the test device.
  parameter word_t TEST_ID = 32'h0c0d_e001
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [MASTERS-1:0][ADDR_W-1:0] ADDRESS,
  input wire logic [MASTERS-1:0] READ,
  input wire logic [MASTERS-1:0] WRITE,
  input wire logic [MASTERS-1:0][DATA_W-1:0] WRITEDATA,
  input wire logic [MASTERS-1:0][3:0] BYTEENABLE,
  output logic [DATA_W-1:0] READDATA,
  output logic [MASTERS-1:0] WAITREQUEST,
  output ctrl_s CTRL_OUT,
  output logic CTRL_STB,
  output mode_t MODE_OUT,
  output val_t [REPS_MAX-1:0] VAL_OUT,
  output logic [REPS_MAX-1:0] VAL_STB,
  input wire logic [REPS_MAX-1:0][DATA_W-1:0] STAT_IN,
  output logic [REPS_MAX-1:0] STAT_ACK,
  output out_regs_s OUT_REGS,
  output ext_req_s EXT_REQ,
  output logic [EXT_ADDRBITS-1:0] EXT_ADR,
  input wire logic [DATA_W-1:0] EXT_DAT_R,
  input wire logic EXT_ACK
);

  localparam int MIDX_W = (MASTERS > 1) ? $clog2(MASTERS) : 1;
  localparam int EXT_LSB = EXT_ADDRBITS + 2;
  // Words below this byte offset are kept free of registers; only the test
  // device, which owns the start of the space, may answer there.
  localparam logic [ADDR_W-1:0] RSV_END = ADDR_W'(4 * RESERVED_WORDS);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  // Reset falls at once but leaves on a clock edge, so that every register
  // below comes out of reset on the same edge and none sees a torn release.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************************************
  // Master selection and address decode
  // ****************************************************************
  logic any_req;
  logic [MIDX_W-1:0] next_sel;
  logic [MIDX_W-1:0] sel;
  logic [ADDR_W-1:0] a_addr;
  logic a_wr;
  logic [3:0] a_be;
  word_t a_wd;
  logic hit_ext;
  logic in_rsv;
  word_t rd_val;
  logic wr_ctrl;
  logic wr_mode;
  logic wr_scr;
  logic [REPS_MAX-1:0] wr_val;
  logic [REPS_MAX-1:0] rd_stat;
  bus_state_e state;
  logic take;
  ctrl_s ctrl;
  mode_t mode;
  val_t [REPS_MAX-1:0] val;
  word_t scratch;
  logic ctrl_stb;
  logic [REPS_MAX-1:0] val_stb;
  logic [REPS_MAX-1:0] stat_ack;

  // Lanes whose enable is low keep their old byte, so a narrow write never
  // disturbs the neighbouring fields of the same word.
  function automatic word_t merge(word_t old, word_t nw, logic [3:0] be);
    word_t res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  // Fixed priority is simple, but a high index master can starve while a
  // lower one keeps the bus busy.
  // lowest index wins
  always_comb begin
    any_req = 1'b0;
    next_sel = '0;
    for (int i = MASTERS - 1; i >= 0; i--) begin
      if (READ[i] || WRITE[i]) begin
        any_req = 1'b1;
        next_sel = MIDX_W'(i);
      end
    end
  end

  always_comb begin
    a_addr = ADDRESS[next_sel];
    a_wr = WRITE[next_sel];
    a_be = BYTEENABLE[next_sel];
    a_wd = WRITEDATA[next_sel];
    hit_ext = a_addr[ADDR_W-1:EXT_LSB] == EXT_BASE[ADDR_W-1:EXT_LSB];
    rd_val = '0;
    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    wr_scr = 1'b0;
    wr_val = '0;
    rd_stat = '0;
    in_rsv = a_addr < RSV_END;
    if (TESTDEV_ENA != 0 && a_addr == TEST_ID_OFS) begin
      rd_val = TEST_ID;
    end
    if (TESTDEV_ENA != 0 && a_addr == TEST_SCRATCH_OFS) begin
      rd_val = scratch;
      wr_scr = a_wr;
    end
    if (!in_rsv && a_addr == CTRL_OFS) begin
      rd_val = {{(DATA_W-CTRL_W){1'b0}}, 3'h0, ctrl.pll_reset, ctrl.freq};
      wr_ctrl = a_wr;
    end
    if (HAS_MODE == 1 && !in_rsv && a_addr == MODE_OFS) begin
      rd_val = {{(DATA_W-MODE_W){mode[MODE_W-1]}}, mode};
      wr_mode = a_wr;
    end
    for (int i = 0; i < VAL_REPS; i++) begin
      if (!in_rsv && a_addr == VAL_BASE + ADDR_W'(4 * i)) begin
        rd_val = {{(DATA_W-VAL_W){1'b0}}, val[i]};
        wr_val[i] = a_wr;
      end
    end
    for (int i = 0; i < STAT_REPS; i++) begin
      if (!in_rsv && a_addr == STAT_BASE + ADDR_W'(4 * i)) begin
        rd_val = STAT_IN[i];
        rd_stat[i] = !a_wr;
      end
    end
  end

  // Writes into the external range never touch local storage; the slot
  // keeps them, so a stray decode cannot corrupt a control register.
  // only a taken write stores
  assign take = (state == ST_IDLE) && any_req && !hit_ext;

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // Every access costs at least one wait cycle; that buys a registered
  // answer and keeps WAITREQUEST straight from a flip-flop.
  // one answer per access
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      sel <= '0;
      WAITREQUEST <= '1;
      READDATA <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (any_req) begin
            sel <= next_sel;
            if (hit_ext) begin
              state <= ST_EXT;
            end else begin
              READDATA <= a_wr ? '0 : rd_val;
              WAITREQUEST[next_sel] <= 1'b0;
              state <= ST_DONE;
            end
          end
        end
        ST_EXT: begin
          // There is no timeout here: a slot that never answers holds the
          // bus for good, so every slot must answer each access it sees.
          if (EXT_ACK) begin
            READDATA <= EXT_REQ.we ? '0 : EXT_DAT_R;
            WAITREQUEST[sel] <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          WAITREQUEST <= '1;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // External slot
  // ****************************************************************
  // The slot only sees its own low address bits; its contents live
  // outside and answer through EXT_ACK.
  // forward low address bits
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      EXT_REQ <= '0;
      EXT_ADR <= '0;
    end else if (state == ST_IDLE && any_req && hit_ext) begin
      EXT_REQ.cyc <= 1'b1;
      EXT_REQ.stb <= 1'b1;
      EXT_REQ.we <= a_wr;
      EXT_REQ.sel <= a_be;
      EXT_REQ.dat <= a_wd;
      EXT_ADR <= a_addr[EXT_LSB-1:2];
    end else if (state == ST_EXT && EXT_ACK) begin
      EXT_REQ.cyc <= 1'b0;
      EXT_REQ.stb <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  word_t ctrl_new;

  assign ctrl_new = merge(word_t'(ctrl), a_wd, a_be);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RST;
    end else if (take && wr_ctrl) begin
      ctrl <= ctrl_s'(ctrl_new[CTRL_W-1:0]);
    end else begin
      // Each answer leaves one idle cycle, so two launch pulses from back to
      // back writes never merge into one longer pulse.
      // trigger clears next cycle
      ctrl.launch <= LAUNCH_RST;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_stb <= 1'b0;
    end else begin
      ctrl_stb <= (CTRL_STB_ENA == 1) && take && wr_ctrl;
    end
  end

  // Only byte lane 0 carries the mode bits; a write without it is answered
  // but changes nothing.
  // present only when flag is one
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= MODE_RST;
    end else if (HAS_MODE == 1 && take && wr_mode) begin
      mode <= a_be[0] ? a_wd[MODE_W-1:0] : mode;
    end
  end

  // The scratch word lets software prove that writes land before it trusts
  // any other register of the block.
  // scratch word of test device
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      scratch <= SCRATCH_RST;
    end else if (take && wr_scr) begin
      scratch <= merge(scratch, a_wd, a_be);
    end
  end

  // ****************************************************************
  // Register vectors
  // ****************************************************************
  // Slots beyond the configured count stay at reset and never decode,
  // so a count of zero still leaves a vector-shaped port.
  // indexed vector instances
  for (genvar g = 0; g < REPS_MAX; g++) begin : g_rep
    word_t val_new;

    assign val_new = merge({{(DATA_W-VAL_W){1'b0}}, val[g]}, a_wd, a_be);

    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        val[g] <= VAL_RST;
      end else if (take && wr_val[g]) begin
        val[g] <= val_new[VAL_W-1:0];
      end
    end

    // An acknowledge on a write would tell user logic that a status value
    // was consumed when it was not, so only reads raise it.
    // vector write strobes
    always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
        val_stb[g] <= 1'b0;
        stat_ack[g] <= 1'b0;
      end else begin
        val_stb[g] <= (VAL_STB_ENA == 1) && take && wr_val[g];
        stat_ack[g] <= (STAT_ACK_ENA == 1) && take && rd_stat[g];
      end
    end
  end

  // ****************************************************************
  // User-side outputs
  // ****************************************************************
  // The selection is by parameter, so every used port is still a flip-flop; the unused set is tied to zero.
  // composite or separate outputs
  assign CTRL_OUT = (AGGR_OUTS != 0) ? '0 : ctrl;
  assign CTRL_STB = (AGGR_OUTS != 0) ? 1'b0 : ctrl_stb;
  assign MODE_OUT = (AGGR_OUTS != 0) ? '0 : mode;
  assign VAL_OUT = (AGGR_OUTS != 0) ? '0 : val;
  assign VAL_STB = (AGGR_OUTS != 0) ? '0 : val_stb;
  assign STAT_ACK = (AGGR_OUTS != 0) ? '0 : stat_ack;
  assign OUT_REGS.ctrl = (AGGR_OUTS != 0) ? ctrl : '0;
  assign OUT_REGS.ctrl_stb = (AGGR_OUTS != 0) ? ctrl_stb : 1'b0;
  assign OUT_REGS.mode = (AGGR_OUTS != 0) ? mode : '0;
  assign OUT_REGS.val = (AGGR_OUTS != 0) ? val : '0;
  assign OUT_REGS.val_stb = (AGGR_OUTS != 0) ? val_stb : '0;
  assign OUT_REGS.stat_ack = (AGGR_OUTS != 0) ? stat_ack : '0;

endmodule : regbank

// ===== dv/regbank_monitor.sv
`timescale 1ns/1ns
module regbank_monitor
  import regbank_pkg::*;
#(
  parameter int MASTERS = 1,
  parameter int EXT_ADDRBITS = 4
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [MASTERS-1:0][ADDR_W-1:0] ADDRESS,
  input wire logic [MASTERS-1:0] READ,
  input wire logic [MASTERS-1:0] WRITE,
  input wire logic [DATA_W-1:0] READDATA,
  input wire logic [MASTERS-1:0] WAITREQUEST,
  input wire ctrl_s CTRL_OUT,
  input wire logic CTRL_STB,
  input wire logic [REPS_MAX-1:0][DATA_W-1:0] STAT_IN,
  input wire logic [REPS_MAX-1:0] STAT_ACK,
  input wire ext_req_s EXT_REQ,
  input wire logic [EXT_ADDRBITS-1:0] EXT_ADR,
  input wire logic [DATA_W-1:0] EXT_DAT_R,
  input wire logic EXT_ACK
);
  // ****************************************************************
  // Bus answers and user side pulses
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic wr_ctrl;
  logic rd_stat;
  assign wr_ctrl = !WAITREQUEST[0] && WRITE[0] && ADDRESS[0] == CTRL_OFS;
  assign rd_stat = !WAITREQUEST[0] && READ[0] && ADDRESS[0] == STAT_BASE;
  answer_pulse_a: assert property (!WAITREQUEST[0] |=> WAITREQUEST[0])
    else $error("waitrequest low for more than one cycle");
  ctrl_strobe_a: assert property (CTRL_STB == wr_ctrl)
    else $error("control strobe does not match the write");
  trigger_clear_a: assert property (CTRL_OUT.launch != 3'h0 |=> CTRL_OUT.launch == 3'h0)
    else $error("trigger field held longer than one cycle");
  trigger_read_a: assert property (!WAITREQUEST[0] && READ[0] && ADDRESS[0] == CTRL_OFS
    |-> READDATA[7:5] == 3'h0) else $error("trigger field read as non-zero");
  stat_data_a: assert property (rd_stat |-> READDATA == $past(STAT_IN[0]))
    else $error("status read data differs from user input");
  stat_ack_a: assert property (STAT_ACK[0] == rd_stat)
    else $error("status acknowledge does not match the read");
  ctrl_hold_a: assert property ($changed(CTRL_OUT[4:0]) |-> wr_ctrl)
    else $error("control register changed without a write");
  ext_forward_a: assert property ($rose(EXT_REQ.cyc) |-> EXT_REQ.stb &&
    EXT_ADR == ADDRESS[0][EXT_ADDRBITS+1:2] && EXT_REQ.we == WRITE[0])
    else $error("external request carries wrong address or direction");
  ext_answer_a: assert property (EXT_ACK && EXT_REQ.cyc |=> !EXT_REQ.cyc &&
    !WAITREQUEST[0] && (WRITE[0] || READDATA == $past(EXT_DAT_R)))
    else $error("external answer not passed back");
endmodule : regbank_monitor

bind regbank regbank_monitor #(.MASTERS(MASTERS), .EXT_ADDRBITS(EXT_ADDRBITS)) regbank_monitor_i (
  .CLK(CLK), .RESET_N(RESET_N), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
  .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .CTRL_OUT(CTRL_OUT), .CTRL_STB(CTRL_STB),
  .STAT_IN(STAT_IN), .STAT_ACK(STAT_ACK), .EXT_REQ(EXT_REQ), .EXT_ADR(EXT_ADR),
  .EXT_DAT_R(EXT_DAT_R), .EXT_ACK(EXT_ACK));

// ===== dv/ext_slot.sv
`timescale 1ns/1ns
module ext_slot
  import regbank_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire ext_req_s req,
  input wire logic [3:0] adr,
  input wire logic [3:0] delay,
  output word_t dat_r,
  output logic ack
);
  word_t mem [16];
  logic [3:0] cnt;
  // ****************************************************************
  // Slave side of the classic single cycle
  // ****************************************************************
  // every access answered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      ack <= 1'b0;
      dat_r <= '0;
    end else begin
      ack <= 1'b0;
      // Data lines toggle on every cycle but a read answer, so stale values never pass for a match.
      dat_r <= ~dat_r;
      if (req.cyc && req.stb && !ack) begin
        if (cnt == delay) begin
          ack <= 1'b1;
          cnt <= 4'h0;
          if (req.we) mem[adr] <= req.dat;
          else dat_r <= mem[adr];
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : ext_slot

// ===== dv/regbank_tb.sv
`timescale 1ns/1ns
module regbank_tb import regbank_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  word_t writedata = '0;
  logic [3:0] byteenable = 4'hf;
  word_t readdata;
  logic waitrequest;
  ctrl_s ctrl_out;
  logic ctrl_stb;
  mode_t mode_out;
  val_t [REPS_MAX-1:0] val_out;
  logic [REPS_MAX-1:0] val_stb;
  logic [REPS_MAX-1:0][DATA_W-1:0] stat_in = '0;
  logic [REPS_MAX-1:0] stat_ack;
  out_regs_s out_regs;
  ext_req_s ext_req;
  logic [3:0] ext_adr;
  word_t ext_dat_r;
  logic ext_ack;
  logic [3:0] slot_delay = 4'h0;
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  int stb_cnt = 0;
  int vstb_cnt = 0;
  int sack_cnt = 0;
  ctrl_s aggr_ctrl;
  out_regs_s aggr_regs;
  logic [2:0] launch_seen = 3'h0;
  word_t rd;
  // Arbitrary identification value.
  localparam word_t ID = 32'h5a5a_0001;

  regbank #(.TEST_ID(ID)) regbank_i (.CLK(clk), .RESET_N(reset_n), .ADDRESS(address),
    .READ(read), .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
    .READDATA(readdata), .WAITREQUEST(waitrequest), .CTRL_OUT(ctrl_out), .CTRL_STB(ctrl_stb),
    .MODE_OUT(mode_out), .VAL_OUT(val_out), .VAL_STB(val_stb), .STAT_IN(stat_in),
    .STAT_ACK(stat_ack), .OUT_REGS(out_regs), .EXT_REQ(ext_req), .EXT_ADR(ext_adr),
    .EXT_DAT_R(ext_dat_r), .EXT_ACK(ext_ack));
  ext_slot ext_slot_i (.clk(clk), .reset_n(reset_n), .req(ext_req), .adr(ext_adr),
    .delay(slot_delay), .dat_r(ext_dat_r), .ack(ext_ack));
  // A second copy with aggregated outputs; its bus stays idle throughout.
  if (1'b1) begin : g_aggr
    regbank #(.TEST_ID(ID), .AGGR_OUTS(1)) regbank_i (.CLK(clk), .RESET_N(reset_n),
      .ADDRESS(8'h00), .READ(1'b0), .WRITE(1'b0), .WRITEDATA(32'h0), .BYTEENABLE(4'h0),
      .READDATA(), .WAITREQUEST(), .CTRL_OUT(aggr_ctrl), .CTRL_STB(), .MODE_OUT(),
      .VAL_OUT(), .VAL_STB(), .STAT_IN('0), .STAT_ACK(), .OUT_REGS(aggr_regs), .EXT_REQ(),
      .EXT_ADR(), .EXT_DAT_R(32'h0), .EXT_ACK(1'b0));
  end

  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (ctrl_stb === 1'b1) stb_cnt++;
    if (ctrl_out.launch !== 3'h0) launch_seen = ctrl_out.launch;
    for (int i = 0; i < REPS_MAX; i++) begin
      if (val_stb[i] === 1'b1) vstb_cnt++;
      if (stat_ack[i] === 1'b1) sack_cnt++;
    end
    if (cycles == 20000) begin
      errors++;
      $display("BAD %0t timeout", $time);
      report_and_stop();
    end
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input word_t got, input word_t exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input word_t d,
    input logic [3:0] be);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input word_t exp);
    bus(1'b0, a, '0, 4'hf);
    chk(rd, exp);
  endtask : rd_chk
  task automatic report_and_stop;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_defaults;
    chk(word_t'(ctrl_out), 32'h11);
    rd_chk(CTRL_OFS, 32'h11);
    rd_chk(MODE_OFS, 32'h0);
    rd_chk(VAL_BASE, 32'h0);
    rd_chk(TEST_ID_OFS, ID);
  endtask : t_defaults
  task automatic t_ctrl;
    bus(1'b1, CTRL_OFS, 32'hffff_ffe6, 4'hf);
    rd_chk(CTRL_OFS, 32'h06);
    chk({29'h0, launch_seen}, 32'h7);
    chk(word_t'(ctrl_out), 32'h06);
    bus(1'b1, CTRL_OFS, 32'h06, 4'hf);
    rd_chk(CTRL_OFS, 32'h06);
    chk(word_t'(stb_cnt), 32'h2);
  endtask : t_ctrl
  task automatic t_regs;
    bus(1'b1, MODE_OFS, 32'h9, 4'hf);
    rd_chk(MODE_OFS, 32'hffff_fff9);
    chk({28'h0, mode_out}, 32'h9);
    bus(1'b1, VAL_BASE + 8'h04, 32'hdead_beef, 4'hf);
    bus(1'b1, VAL_BASE, 32'h0000_1234, 4'h1);
    rd_chk(VAL_BASE + 8'h04, 32'h0000_beef);
    rd_chk(VAL_BASE, 32'h0000_0034);
    chk({16'h0, val_out[1]}, 32'hbeef);
    chk({16'h0, val_out[2]}, 32'h0);
    chk({31'h0, |out_regs}, 32'h0);
    chk(word_t'(vstb_cnt), 32'h2);
    chk(word_t'(aggr_regs.ctrl), 32'h11);
    chk(word_t'(aggr_ctrl), 32'h0);
  endtask : t_regs
  task automatic t_stat;
    stat_in[0] <= 32'h1234_5678;
    stat_in[1] <= 32'ha5a5_0f0f;
    bus(1'b1, STAT_BASE, 32'h0, 4'hf);
    rd_chk(STAT_BASE, 32'h1234_5678);
    rd_chk(STAT_BASE + 8'h04, 32'ha5a5_0f0f);
    rd_chk(STAT_BASE + 8'h08, 32'h0);
    chk(word_t'(sack_cnt), 32'h2);
  endtask : t_stat
  task automatic t_map;
    bus(1'b1, 8'h0c, 32'hffff_ffff, 4'hf);
    rd_chk(8'h0c, 32'h0);
    rd_chk(8'h08, 32'h0);
    rd_chk(8'h80, 32'h0);
    bus(1'b1, TEST_SCRATCH_OFS, 32'h1234_abcd, 4'hf);
    rd_chk(TEST_SCRATCH_OFS, 32'h1234_abcd);
  endtask : t_map
  task automatic t_ext;
    bus(1'b1, EXT_BASE + 8'h04, 32'h1111_2222, 4'hf);
    slot_delay <= 4'h5;
    bus(1'b1, EXT_BASE + 8'h3c, 32'h3333_4444, 4'hf);
    rd_chk(EXT_BASE + 8'h04, 32'h1111_2222);
    slot_delay <= 4'h0;
    rd_chk(EXT_BASE + 8'h3c, 32'h3333_4444);
  endtask : t_ext
  task automatic t_reset;
    bus(1'b1, CTRL_OFS, 32'h0a, 4'hf);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(word_t'(ctrl_out), 32'h11);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(CTRL_OFS, 32'h11);
  endtask : t_reset

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_defaults();
    t_ctrl();
    t_regs();
    t_stat();
    t_map();
    t_ext();
    t_reset();
    report_and_stop();
  end
endmodule : regbank_tb
